// [pkg/cmt_defines.svh]
/*
  constants for the cache and mmu test state register: bit positions,
  width, reset value and coprocessor decode values.
  assumes inclusion by bare name from package and design files.
*/
`ifndef CMT_DEFINES_SVH
`define CMT_DEFINES_SVH

`define CMT_WIDTH 13
`define CMT_RESET 13'h0000
`define CMT_WR_MASK 13'h1ffe
`define CMT_BIT_DC_STREAM_DIS 12
`define CMT_BIT_IC_STREAM_DIS 11
`define CMT_BIT_DC_FILL_DIS 10
`define CMT_BIT_IC_FILL_DIS 9
`define CMT_BIT_CLOCK_SELECT_DISABLE 8
`define CMT_BIT_ASYNC_OVR 7
`define CMT_BIT_NOTFAST_OVR 6
`define CMT_BIT_DC_FORCE_NC 5
`define CMT_BIT_IC_FORCE_NC 4
`define CMT_BIT_MMU_TEST 3
`define CMT_BIT_INSTR_TLB_MISS_ABORT 2
`define CMT_BIT_DATA_TLB_MISS_ABORT 1
`define CMT_BIT_INTERP_MODE 0
`define CMT_COPROC_NUM 4'hf
`define CMT_OPC1 3'h0
`define CMT_CRN 4'hf
`define CMT_CRM 4'h0
`define CMT_OPC2 3'h0

`endif

// [pkg/cmt_pkg.sv]
/*
  types for the cache and mmu test state register.
  assumes cmt_defines.svh is on the include path.
*/
`include "cmt_defines.svh"

package cmt_pkg;
  typedef logic [`CMT_WIDTH-1:0] state_word_t;
  // {async, notfast} pair
  typedef enum logic [1:0] {
    MODE_CORE_BUS = 2'h0,
    MODE_SYNC = 2'h1,
    MODE_RESERVED = 2'h2,
    MODE_ASYNC = 2'h3
  } clock_mode_t;
endpackage : cmt_pkg

// [logic/cache_mmu_test_state.sv]
/*
  test state register of the system control coprocessor: coprocessor
  read and write port, scan chain port, and the decoded test overrides
  that steer the caches, the tlbs and clock-mode selection.
  assumes the coprocessor and scan ports come from logic on the same
  clock, and that the core fills rdata bits above 12 as it likes.
*/
// What this block does
// [R01] reset clears all thirteen bits so no override is active
// [R02] coprocessor write to test space op 0, c0, op 0 updates bits 12..1
// [R03] coprocessor read returns bits 12..0, upper result bits undefined
// [R04] bit 0 changes only through scan chain 15, never by coprocessor write
// [R05] software writes zero in bits 31..13 and bit 0
// [R06] scan chain may also read and write bits 12..1
// [R07] bit 12 stops data cache streaming; word returned after linefill
// [R08] bit 11 stops instruction cache streaming; delivery after linefill
// [R09] bit 10 disables data cache linefills
// [R10] bit 9 disables instruction cache linefills
// [R11] bit 8 disables control register 1 clock-select bits 31..30
// [R12] bits 7..6 override code: core bus, sync, reserved, async
// [R13] bits 5 and 4 force non-cacheable data and instruction cache
// [R14] bit 3 enables extra tlb index auto-increment
// [R15] bit 2 disables instruction tlb hardware walks
// [R16] bit 1 disables data tlb hardware walks
// [R17] bit 0 enables interpreted coprocessor mode
// [R18] linefill disabled: miss fetches single word, no allocate, hits served
// [R19] effective select = control bit and not bit 8, or override bit
// [R20] forced non-cacheable: single accesses, write hits update, read hits ignored
// [R21] index advances on ram writes, or any cam/ram access with bit 3
// [R22] reserved clock code 10 is stored and read back unchanged
`timescale 1ns/100ps
`include "cmt_defines.svh"

module cache_mmu_test_state (
  input wire logic clock,
  input wire logic arst_n,
  // coprocessor transfer
  input wire logic cp_valid,
  input wire logic cp_is_write,
  input wire logic [3:0] cp_num,
  input wire logic [2:0] cp_opc1,
  input wire logic [3:0] cp_crn,
  input wire logic [3:0] cp_crm,
  input wire logic [2:0] cp_opc2,
  input wire logic [31:0] cp_wdata,
  output logic cp_hit,
  output logic [31:0] cp_rdata,
  // debug scan chain 15, test state selected
  input wire logic scan_write,
  input wire logic [`CMT_WIDTH-1:0] scan_wdata,
  output logic [`CMT_WIDTH-1:0] scan_rdata,
  // control register 1 clock selects
  input wire logic ctrl_async_select_bit,
  input wire logic ctrl_notfast_select_bit,
  output logic async_clock_eff,
  output logic not_core_bus_clock_mode_eff,
  output cmt_pkg::clock_mode_t clock_mode,
  // data cache policy
  input wire logic d_region_cacheable,
  output logic d_cacheable_eff,
  output logic d_linefill_en,
  output logic d_stream_en,
  output logic d_read_hit_use,
  output logic d_write_hit_update,
  // instruction cache policy
  input wire logic i_region_cacheable,
  output logic i_cacheable_eff,
  output logic i_linefill_en,
  output logic i_stream_en,
  output logic i_read_hit_use,
  // tlb test index pointer
  input wire logic tlb_entry_ram_write,
  input wire logic tlb_entry_ram_read,
  input wire logic tlb_cam_write,
  input wire logic tlb_cam_read,
  output logic tlb_index_advance,
  // mmu and debug controls
  output logic instruction_tlb_walk_en,
  output logic data_tlb_walk_en,
  output logic interp_mode
);

  cmt_pkg::state_word_t state_reg, state_next;
  logic [31:0] rdata_reg, rdata_next;
  logic decode_hit;
  logic cp_wr, cp_rd;

  // full decode of the test state address in test register space
  assign decode_hit = (cp_num == `CMT_COPROC_NUM) && (cp_opc1 == `CMT_OPC1) && (cp_crn == `CMT_CRN)
                      && (cp_crm == `CMT_CRM) && (cp_opc2 == `CMT_OPC2);
  assign cp_wr = cp_valid && cp_is_write && decode_hit;
  assign cp_rd = cp_valid && !cp_is_write && decode_hit;
  assign cp_hit = cp_valid && decode_hit;

  always_comb begin
    state_next = state_reg;
    rdata_next = rdata_reg;
    if (scan_write) begin
      // scan carries the whole word; it wins over a coprocessor write
      state_next = scan_wdata; // [R04] [R06] [R22]
    end else if (cp_wr) begin
      state_next = (state_reg & ~`CMT_WR_MASK) | (cp_wdata[`CMT_WIDTH-1:0] & `CMT_WR_MASK); // [R02] [R04] [R22]
    end
    if (cp_rd) begin
      // undefined upper bits read as zero
      rdata_next = {{(32-`CMT_WIDTH){1'b0}}, state_reg}; // [R03]
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= `CMT_RESET; // [R01]
      rdata_reg <= 32'h0000_0000;
    end else begin
      state_reg <= state_next;
      rdata_reg <= rdata_next;
    end
  end

  assign cp_rdata = rdata_reg;
  assign scan_rdata = state_reg; // [R06]

  // clock-mode selection
  assign async_clock_eff = (ctrl_async_select_bit & ~state_reg[`CMT_BIT_CLOCK_SELECT_DISABLE])
                           | state_reg[`CMT_BIT_ASYNC_OVR]; // [R11] [R19]
  assign not_core_bus_clock_mode_eff = (ctrl_notfast_select_bit & ~state_reg[`CMT_BIT_CLOCK_SELECT_DISABLE])
                           | state_reg[`CMT_BIT_NOTFAST_OVR]; // [R11] [R19]
  // code 10 passes through; the clock logic gives it no meaning
  assign clock_mode = cmt_pkg::clock_mode_t'({async_clock_eff, not_core_bus_clock_mode_eff}); // [R12] [R22]

  // data cache policy
  assign d_cacheable_eff = d_region_cacheable & ~state_reg[`CMT_BIT_DC_FORCE_NC]; // [R13] [R20]
  // fill off: miss is a single non-allocating word, hits still served
  assign d_linefill_en = d_cacheable_eff & ~state_reg[`CMT_BIT_DC_FILL_DIS]; // [R09] [R18]
  assign d_stream_en = d_linefill_en & ~state_reg[`CMT_BIT_DC_STREAM_DIS]; // [R07]
  assign d_read_hit_use = d_cacheable_eff; // [R18] [R20]
  // write hits keep the cache coherent even when forced non-cacheable
  assign d_write_hit_update = 1'b1; // [R20]

  // instruction cache policy
  assign i_cacheable_eff = i_region_cacheable & ~state_reg[`CMT_BIT_IC_FORCE_NC]; // [R13]
  assign i_linefill_en = i_cacheable_eff & ~state_reg[`CMT_BIT_IC_FILL_DIS]; // [R10] [R18]
  assign i_stream_en = i_linefill_en & ~state_reg[`CMT_BIT_IC_STREAM_DIS]; // [R08]
  assign i_read_hit_use = i_cacheable_eff; // [R18]

  // tlb index pointer advance
  assign tlb_index_advance = tlb_entry_ram_write
                             | (state_reg[`CMT_BIT_MMU_TEST]
                                & (tlb_entry_ram_read | tlb_cam_write | tlb_cam_read)); // [R14] [R21]

  // mmu and debug controls
  assign instruction_tlb_walk_en = ~state_reg[`CMT_BIT_INSTR_TLB_MISS_ABORT]; // [R15]
  assign data_tlb_walk_en = ~state_reg[`CMT_BIT_DATA_TLB_MISS_ABORT]; // [R16]
  assign interp_mode = state_reg[`CMT_BIT_INTERP_MODE]; // [R17]

  // checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!arst_n);

  sequence cp_write_only_s;
    cp_wr && !scan_write;
  endsequence

  sequence cp_read_s;
    cp_rd && !scan_write && !cp_wr;
  endsequence

  // one quiet cycle between transfers, as the core spaces them
  sequence idle_s;
    !scan_write && !cp_wr;
  endsequence

  sequence scan_idle_read_s;
    scan_write ##1 idle_s ##1 cp_read_s;
  endsequence

  sequence write_idle_read_s;
    cp_write_only_s ##1 idle_s ##1 cp_read_s;
  endsequence

  chk_write_upper_bits: assert property (cp_write_only_s |=> state_reg[12:1] == $past(cp_wdata[12:1])) // [R02]
    else $error("coprocessor write did not load bits 12 to 1");

  chk_bit0_kept: assert property (cp_write_only_s |=> state_reg[0] == $past(state_reg[0])) // [R04]
    else $error("coprocessor write changed bit 0");

  chk_bit0_scan_only: assert property (!scan_write |=> $stable(state_reg[0])) // [R04]
    else $error("bit 0 changed without a scan write");

  chk_scan_load: assert property (scan_write |=> state_reg == $past(scan_wdata)) // [R06]
    else $error("scan write did not load the register");

  chk_read_data: assert property (cp_read_s |=> cp_rdata == {19'h0_0000, $past(state_reg)}) // [R03]
    else $error("coprocessor read returned wrong data");

  chk_reset_clear: assert property ($rose(arst_n) |-> state_reg == 13'h0000) // [R01]
    else $error("register not clear after reset");

  chk_reserved_code: assert property (cp_write_only_s and (cp_wdata[7:6] == 2'h2) |=> state_reg[7:6] == 2'h2) // [R22]
    else $error("reserved clock code not stored");

  chk_clock_select: assert property (
    {async_clock_eff, not_core_bus_clock_mode_eff}
      == (({ctrl_async_select_bit, ctrl_notfast_select_bit} & {2{~state_reg[8]}}) | state_reg[7:6])) // [R19]
    else $error("effective clock select wrong");

  chk_index_advance: assert property (tlb_index_advance == (tlb_entry_ram_write
    || (state_reg[3] && (tlb_entry_ram_read || tlb_cam_read || tlb_cam_write)))) // [R21]
    else $error("tlb index advance wrong");

  chk_fill_policy: assert property (state_reg[10] |-> !d_linefill_en && !d_stream_en) // [R09]
    else $error("data linefill not disabled");

  chk_force_nc: assert property (state_reg[5] |-> !d_cacheable_eff && !d_read_hit_use) // [R20]
    else $error("data force non-cacheable not applied");

  chk_walk_ctrl: assert property (instruction_tlb_walk_en == !state_reg[2] // [R15] [R16]
    && data_tlb_walk_en == !state_reg[1])
    else $error("tlb walk enables wrong");

  chk_decode_hit: assert property (cp_hit == (cp_valid && cp_num == 4'hf && cp_opc1 == 3'h0 // [R02]
    && cp_crn == 4'hf && cp_crm == 4'h0 && cp_opc2 == 3'h0))
    else $error("test state address decode wrong");

  chk_decode_miss: assert property (cp_valid && !cp_hit && !scan_write // [R02]
    |=> $stable(state_reg) && $stable(cp_rdata))
    else $error("transfer to another address touched the register");

  chk_rdata_hold: assert property (!cp_rd |=> $stable(cp_rdata)) // [R03]
    else $error("read data changed without a read");

  chk_idle_hold: assert property (!cp_wr && !scan_write |=> $stable(state_reg)) // [R02] [R04]
    else $error("register changed without a write");

  chk_upper_zero: assert property (cp_read_s |=> cp_rdata[31:13] == 19'h0_0000) // [R03]
    else $error("upper read bits not zero");

  chk_reset_rdata: assert property ($rose(arst_n) |-> cp_rdata == 32'h0000_0000 && !interp_mode) // [R01]
    else $error("read data or interpreted mode not clear after reset");

  chk_mode_core_bus: assert property (state_reg[8] && state_reg[7:6] == 2'h0 // [R11] [R12]
    |-> clock_mode == cmt_pkg::MODE_CORE_BUS)
    else $error("core bus mode not selected");

  chk_mode_sync: assert property (state_reg[8] && state_reg[7:6] == 2'h1 // [R11] [R12]
    |-> clock_mode == cmt_pkg::MODE_SYNC)
    else $error("synchronous mode not selected");

  chk_mode_reserved: assert property (state_reg[8] && state_reg[7:6] == 2'h2 // [R22]
    |-> clock_mode == cmt_pkg::MODE_RESERVED)
    else $error("reserved code not passed through");

  chk_mode_async: assert property (state_reg[7:6] == 2'h3 // [R12]
    |-> clock_mode == cmt_pkg::MODE_ASYNC)
    else $error("asynchronous mode not selected");

  chk_select_enabled: assert property (!state_reg[8] && state_reg[7:6] == 2'h0 // [R11]
    |-> {async_clock_eff, not_core_bus_clock_mode_eff} == {ctrl_async_select_bit, ctrl_notfast_select_bit})
    else $error("control register selects not used");

  chk_d_stream_off: assert property (state_reg[12] && !state_reg[10] && !state_reg[5] // [R07]
    && d_region_cacheable |-> d_linefill_en && !d_stream_en)
    else $error("data streaming not stopped with linefill kept");

  chk_i_stream_off: assert property (state_reg[11] && !state_reg[9] && !state_reg[4] // [R08]
    && i_region_cacheable |-> i_linefill_en && !i_stream_en)
    else $error("instruction streaming not stopped with linefill kept");

  chk_i_fill: assert property (state_reg[9] |-> !i_linefill_en && !i_stream_en) // [R10]
    else $error("instruction linefill not disabled");

  chk_d_fill_hits: assert property (state_reg[10] && !state_reg[5] && d_region_cacheable // [R18]
    |-> d_read_hit_use && d_cacheable_eff)
    else $error("data hits not served with linefill off");

  chk_i_fill_hits: assert property (state_reg[9] && !state_reg[4] && i_region_cacheable // [R18]
    |-> i_read_hit_use && i_cacheable_eff)
    else $error("instruction hits not served with linefill off");

  chk_i_force_nc: assert property (state_reg[4] |-> !i_cacheable_eff && !i_read_hit_use && !i_linefill_en) // [R13]
    else $error("instruction force non-cacheable not applied");

  chk_d_nc_fill: assert property (state_reg[5] |-> !d_linefill_en && !d_stream_en) // [R13] [R20]
    else $error("data linefill under force non-cacheable");

  chk_normal_cache: assert property (state_reg[12:9] == 4'h0 && state_reg[5:4] == 2'h0 // [R13]
    |-> d_stream_en == d_region_cacheable && i_stream_en == i_region_cacheable)
    else $error("normal cache operation altered");

  chk_index_plain: assert property (!state_reg[3] |-> tlb_index_advance == tlb_entry_ram_write) // [R21]
    else $error("index advanced on a non ram write");

  chk_index_test: assert property (state_reg[3] // [R14]
    && (tlb_cam_read || tlb_cam_write || tlb_entry_ram_read) |-> tlb_index_advance)
    else $error("index not advanced in mmu test");

  chk_interp_scan: assert property (scan_write |=> interp_mode == $past(scan_wdata[0])) // [R04] [R17]
    else $error("interpreted mode does not follow scan bit 0");

  chk_walk_on: assert property (state_reg[2:1] == 2'h0 |-> instruction_tlb_walk_en && data_tlb_walk_en) // [R15] [R16]
    else $error("tlb walks not enabled");

  chk_scan_readback: assert property (scan_idle_read_s |=> cp_rdata[12:0] == $past(scan_wdata, 3)) // [R03] [R06]
    else $error("scan word not read back");

  chk_write_readback: assert property (write_idle_read_s |=> cp_rdata[12:1] == $past(cp_wdata[12:1], 3)) // [R02] [R03]
    else $error("written bits not read back");

endmodule : cache_mmu_test_state

// [sim/core_port_model.sv]
/*
  core side of the test state register: coprocessor transfers and scan
  chain 15 updates, driven one unit after each rising edge.
  assumes the register samples its ports on the rising edge of clock.
*/
`timescale 1ns/100ps
module core_port_model (
  input wire logic clock,
  output logic cp_valid,
  output logic cp_is_write,
  output logic [3:0] cp_num,
  output logic [2:0] cp_opc1,
  output logic [3:0] cp_crn,
  output logic [3:0] cp_crm,
  output logic [2:0] cp_opc2,
  output logic [31:0] cp_wdata,
  input wire logic cp_hit,
  input wire logic [31:0] cp_rdata,
  output logic scan_write,
  output logic [12:0] scan_wdata
);
  initial begin
    {cp_valid, cp_is_write, cp_opc1, cp_opc2, scan_write, cp_crm} = '0;
    cp_num = 4'hf;
    cp_crn = 4'hf;
    cp_wdata = 32'h0;
    scan_wdata = 13'h0;
  end

  // callers keep bits 31..13 and bit 0 zero unless testing their loss
  task automatic xfer(input logic wr, input logic [3:0] crm, input logic [31:0] wd,
                      output logic hit, output logic [31:0] rd);
    @(posedge clock);
    #1;
    {cp_valid, cp_is_write, cp_crm, cp_wdata} = {1'b1, wr, crm, wd};
    @(posedge clock);
    hit = cp_hit;
    #1;
    cp_valid = 1'b0;
    // released bus must not keep looking valid
    cp_wdata = ~wd;
    rd = cp_rdata;
  endtask : xfer

  // whole-word update, so single bits need read-modify-write
  task automatic scan(input logic [12:0] w);
    @(posedge clock);
    #1;
    {scan_write, scan_wdata} = {1'b1, w};
    @(posedge clock);
    #1;
    {scan_write, scan_wdata} = {1'b0, ~w};
  endtask : scan
endmodule : core_port_model

// [sim/cache_mmu_test_state_test.sv]
/*
  self-checking bench for the test state register: coprocessor and scan
  access, then the decoded cache, clock-mode and tlb policy outputs.
  assumes core_port_model drives the coprocessor and scan ports.
*/
`timescale 1ns/100ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin error_cnt++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); end end
module cache_mmu_test_state_test;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic cp_valid, cp_is_write, cp_hit, scan_write, hit, c, lf, async_clock_eff, not_core_bus_clock_mode_eff;
  logic [3:0] cp_num, cp_crn, cp_crm;
  logic [2:0] cp_opc1, cp_opc2;
  logic [31:0] cp_wdata, cp_rdata, rd;
  logic [12:0] scan_wdata, scan_rdata, st;
  logic [1:0] cm;
  logic ctrl_async_select_bit = 1'b0, ctrl_notfast_select_bit = 1'b0;
  cmt_pkg::clock_mode_t clock_mode;
  logic d_region_cacheable = 1'b0, d_cacheable_eff, d_linefill_en, d_stream_en, d_read_hit_use;
  logic i_region_cacheable = 1'b0, i_cacheable_eff, i_linefill_en, i_stream_en, i_read_hit_use;
  logic tlb_entry_ram_write = 1'b0, tlb_entry_ram_read = 1'b0, tlb_cam_write = 1'b0, tlb_cam_read = 1'b0;
  logic d_write_hit_update, tlb_index_advance, instruction_tlb_walk_en, data_tlb_walk_en, interp_mode;
  int error_cnt = 0;
  int checks = 0;
  always #5 clock = ~clock;
  cache_mmu_test_state uut (.clock, .arst_n, .cp_valid, .cp_is_write, .cp_num, .cp_opc1, .cp_crn,
    .cp_crm, .cp_opc2, .cp_wdata, .cp_hit, .cp_rdata, .scan_write, .scan_wdata, .scan_rdata,
    .ctrl_async_select_bit, .ctrl_notfast_select_bit, .async_clock_eff, .not_core_bus_clock_mode_eff, .clock_mode,
    .d_region_cacheable, .d_cacheable_eff, .d_linefill_en, .d_stream_en, .d_read_hit_use,
    .d_write_hit_update, .i_region_cacheable, .i_cacheable_eff, .i_linefill_en, .i_stream_en,
    .i_read_hit_use, .tlb_entry_ram_write, .tlb_entry_ram_read, .tlb_cam_write, .tlb_cam_read,
    .tlb_index_advance, .instruction_tlb_walk_en, .data_tlb_walk_en, .interp_mode);
  core_port_model core (.clock, .cp_valid, .cp_is_write, .cp_num, .cp_opc1, .cp_crn, .cp_crm,
    .cp_opc2, .cp_wdata, .cp_hit, .cp_rdata, .scan_write, .scan_wdata);

  task automatic stop_test();
    if (error_cnt == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : stop_test

  initial begin
    #20000;
    error_cnt++;
    stop_test();
  end

  initial begin
    repeat (10) @(posedge clock);
    #1 arst_n = 1'b1;
    `CHK({scan_rdata, instruction_tlb_walk_en, data_tlb_walk_en, interp_mode}, 16'h0006)
    core.xfer(1'b0, 4'h0, 32'h0, hit, rd);
    `CHK(rd, 32'h0000_0000)
    // dirty upper bits and bit 0 must be dropped
    core.xfer(1'b1, 4'h0, 32'hffff_ffff, hit, rd);
    `CHK({hit, scan_rdata}, {1'b1, 13'h1ffe})
    core.xfer(1'b0, 4'h0, 32'h0, hit, rd);
    `CHK(rd, 32'h0000_1ffe)
    core.xfer(1'b1, 4'h1, 32'h0, hit, rd);
    `CHK({hit, scan_rdata}, {1'b0, 13'h1ffe})
    core.scan(13'h0001);
    `CHK({interp_mode, scan_rdata}, {1'b1, 13'h0001})
    core.xfer(1'b1, 4'h0, 32'h0000_0aaa, hit, rd);
    `CHK({scan_rdata, instruction_tlb_walk_en, data_tlb_walk_en}, {13'h0aab, 2'h2})
    core.xfer(1'b1, 4'h0, 32'h0000_0554, hit, rd);
    `CHK({scan_rdata, instruction_tlb_walk_en, data_tlb_walk_en}, {13'h0555, 2'h1})
    core.scan(13'h1ffe);
    core.xfer(1'b0, 4'h0, 32'h0, hit, rd);
    `CHK({interp_mode, rd}, {1'b0, 32'h0000_1ffe})
    for (int k = 0; k < 32; k++) begin
      if (k % 4 == 0) core.scan({4'h0, k[4:2], 6'h00});
      @(posedge clock);
      #1 {ctrl_async_select_bit, ctrl_notfast_select_bit} = k[1:0];
      cm = {(k[1] & ~k[4]) | k[3], (k[0] & ~k[4]) | k[2]};
      #1 `CHK({2'(clock_mode), async_clock_eff, not_core_bus_clock_mode_eff}, {cm, cm})
      `CHK(scan_rdata, {4'h0, k[4:2], 6'h00})
    end
    for (int k = 0; k < 16; k++) begin
      core.scan({k[3], k[3], k[2], k[2], 3'h0, k[1], k[1], 4'h0});
      {d_region_cacheable, i_region_cacheable} = {k[0], k[0]};
      c = k[0] & ~k[1];
      lf = c & ~k[2];
      #1 `CHK({d_cacheable_eff, d_linefill_en, d_stream_en, d_read_hit_use, d_write_hit_update},
        {c, lf, lf & ~k[3], c, 1'b1})
      `CHK({i_cacheable_eff, i_linefill_en, i_stream_en, i_read_hit_use},
        {c, lf, lf & ~k[3], c})
    end
    for (int k = 0; k < 32; k++) begin
      if (k % 16 == 0) core.scan({9'h0, k[4], 3'h0});
      @(posedge clock);
      #1 {tlb_cam_read, tlb_cam_write, tlb_entry_ram_read, tlb_entry_ram_write} = k[3:0];
      #1 `CHK(tlb_index_advance, k[0] | (k[4] & (|k[3:1])))
    end
    // second reset in mid-run with overrides set
    core.scan(13'h1fff);
    @(posedge clock);
    #1 arst_n = 1'b0;
    #1 `CHK({scan_rdata, interp_mode, cp_rdata}, 46'h0)
    @(posedge clock);
    #1 arst_n = 1'b1;
    core.xfer(1'b0, 4'h0, 32'h0, hit, rd);
    `CHK({hit, rd, scan_rdata, instruction_tlb_walk_en}, {1'b1, 32'h0, 13'h0, 1'b1})
    stop_test();
  end
endmodule : cache_mmu_test_state_test
